// file: pfsm_pin_function_select_mux.sv
`timescale 1ns/100ps

module pfsm_pin_function_select_mux (
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst,
	input  wire logic                 i_req,
	input  wire logic                 i_we,
	input  wire pfsm_pkg::pfsm_size_t i_size,
	input  wire logic [11:0]          i_addr,
	input  wire logic [31:0]          i_wdata,
	output logic                      o_ready,
	output logic                      o_ack,
	output logic [31:0]               o_rdata,
	output logic                      o_lower_req,
	output logic                      o_lower_we,
	output logic [1:0]                o_lower_be,
	output logic [15:0]               o_lower_wdata,
	input  wire logic [15:0]          i_lower_rdata,
	output logic [15:0]               o_upper_fnc,
	output logic [7:0]                o_cs_fnc,
	output logic [15:0]               o_pio_write_allow,
	output logic [15:0]               o_pin_level,
	input  wire logic [15:0]          i_pio_out,
	input  wire logic [15:0]          i_pio_oe,
	input  wire logic [15:0]          i_pin_in,
	output logic [15:0]               o_pin_out,
	output logic [15:0]               o_pin_oe,
	output logic                      o_uart2_ring_indicator,
	output logic                      o_uart2_carrier_detect,
	output logic                      o_uart2_set_ready,
	output logic                      o_uart2_clear_to_send,
	input  wire logic [7:0]           i_gp_chip_select_n,
	input  wire logic                 i_gp_data_buffer_oe,
	output logic                      o_gp_mem_16bit_ack,
	output logic                      o_gp_io_16bit_ack,
	output logic [7:0]                o_gp_irq_input_n,
	input  wire logic                 i_timer0_output,
	input  wire logic                 i_timer1_output,
	output logic                      o_timer0_input,
	output logic                      o_timer1_input,
	output logic                      o_interval_timer2_gate,
	input  wire logic                 i_boot_rom_select_1,
	input  wire logic                 i_boot_rom_select_2,
	input  wire logic [7:1]           i_cs_pin_in,
	output logic [7:1]                o_cs_pin_out,
	output logic [7:1]                o_cs_pin_oe
);
	import pfsm_pkg::*;

	// ---------------------------------------------------------------
	// Register access sequencer
	// ---------------------------------------------------------------
	pfsm_state_t state;
	pfsm_state_t next_state;
	logic [15:0] upper_fnc;
	logic [15:0] next_upper_fnc;
	logic [7:0]  cs_fnc;
	logic [7:0]  next_cs_fnc;
	logic        ack;
	logic        next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        we_q;
	logic        next_we_q;
	logic [3:0]  be_q;
	logic [3:0]  next_be_q;
	logic [31:0] wdata_q;
	logic [31:0] next_wdata_q;
	logic [3:0]  req_be;
	logic        req_legal;
	logic        hit_c20;
	logic        hit_c24;
	logic        take;

	always_comb begin
		req_be    = 4'h0;
		req_legal = 1'b0;
		case (i_size)
			SIZE_BYTE: begin
				req_be    = 4'(4'h1 << i_addr[1:0]);
				req_legal = 1'b1;
			end
			SIZE_WORD: begin
				req_be    = 4'(4'h3 << i_addr[1:0]);
				req_legal = ~i_addr[0];
			end
			SIZE_DWORD: begin
				req_be    = 4'hf;
				req_legal = (i_addr[1:0] == 2'h0);
			end
			default: begin
				req_be    = 4'h0;
				req_legal = 1'b0;
			end
		endcase
	end

	assign hit_c20 = req_legal && (i_addr[11:2] == OFS_LOWER_FNC[11:2]);
	assign hit_c24 = req_legal && (i_addr[11:2] == OFS_CS_FNC[11:2]);
	assign take    = i_req && (state == ST_IDLE);

	always_comb begin
		next_state     = state;
		next_upper_fnc = upper_fnc;
		next_cs_fnc    = cs_fnc;
		next_ack       = 1'b0;
		next_rdata     = rdata;
		next_we_q      = we_q;
		next_be_q      = be_q;
		next_wdata_q   = wdata_q;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_we_q    = i_we;
					next_be_q    = hit_c20 ? req_be : 4'h0;
					next_wdata_q = i_wdata;
					next_rdata   = 32'h0000_0000;
					if (hit_c20 && (req_be[1:0] != 2'h0)) begin
						// The lower half always goes first.
						next_state = ST_LOWER;
					end else if (hit_c20) begin
						next_state = ST_UPPER;
					end else begin
						next_ack = 1'b1;
						if (hit_c24 && req_be[0]) begin
							if (i_we) begin
								// Reserved bit 0 is not stored and reads 0.
								next_cs_fnc = i_wdata[7:0] & CS_FNC_WRITABLE;
							end
							next_rdata = {24'h00_0000, cs_fnc};
						end
					end
				end
			end
			ST_LOWER: begin
				next_rdata[15:0] = i_lower_rdata;
				if (be_q[3:2] != 2'h0) begin
					next_state = ST_UPPER;
				end else begin
					next_state = ST_IDLE;
					next_ack   = 1'b1;
				end
			end
			ST_UPPER: begin
				next_rdata[31:16] = upper_fnc;
				if (we_q && be_q[2]) begin
					next_upper_fnc[7:0] = wdata_q[23:16];
				end
				if (we_q && be_q[3]) begin
					next_upper_fnc[15:8] = wdata_q[31:24];
				end
				next_state = ST_IDLE;
				next_ack   = 1'b1;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state     <= ST_IDLE;
			upper_fnc <= UPPER_FNC_RESET;
			cs_fnc    <= CS_FNC_RESET;
			ack       <= 1'b0;
			rdata     <= 32'h0000_0000;
			we_q      <= 1'b0;
			be_q      <= 4'h0;
			wdata_q   <= 32'h0000_0000;
		end else begin
			state     <= next_state;
			upper_fnc <= next_upper_fnc;
			cs_fnc    <= next_cs_fnc;
			ack       <= next_ack;
			rdata     <= next_rdata;
			we_q      <= next_we_q;
			be_q      <= next_be_q;
			wdata_q   <= next_wdata_q;
		end
	end

	assign o_ready       = (state == ST_IDLE);
	assign o_ack         = ack;
	assign o_rdata       = rdata;
	assign o_lower_req   = (state == ST_LOWER);
	assign o_lower_we    = (state == ST_LOWER) && we_q;
	assign o_lower_be    = be_q[1:0];
	assign o_lower_wdata = wdata_q[15:0];
	assign o_upper_fnc   = upper_fnc;
	assign o_cs_fnc      = cs_fnc;
	// The outer direction, data, set and clear bits must not take writes
	// while the interface function owns the pin.
	assign o_pio_write_allow = ~upper_fnc;

	// ---------------------------------------------------------------
	// Pin input synchronisers
	// ---------------------------------------------------------------
	logic [22:0] sync1;
	logic [22:0] sync2;
	logic [22:0] next_sync1;
	logic [22:0] next_sync2;

	always_comb begin
		next_sync1 = {i_cs_pin_in, i_pin_in};
		next_sync2 = sync1;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sync1 <= 23'h00_0000;
			sync2 <= 23'h00_0000;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end

	// The level is reported whatever function owns the pin.
	assign o_pin_level = sync2[15:0];

	// ---------------------------------------------------------------
	// Upper programmable pins
	// ---------------------------------------------------------------
	logic [15:0] fn_out;
	logic [15:0] fn_oe;
	logic [15:0] fn_in;

	always_comb begin
		fn_out = 16'hffff;
		fn_oe  = 16'h0000;
		fn_out[UPPER_CS0_BIT]  = i_gp_chip_select_n[0];
		fn_oe[UPPER_CS0_BIT]   = 1'b1;
		fn_out[UPPER_DBUF_BIT] = i_gp_data_buffer_oe;
		fn_oe[UPPER_DBUF_BIT]  = 1'b1;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_upper
			pfsm_pin_cell #(
				.IDLE_A (1'b0),
				.IDLE_B (1'b1)
			) u_cell (
				.i_sel      (upper_fnc[gi]),
				.i_a_out    (i_pio_out[gi]),
				.i_a_oe     (i_pio_oe[gi]),
				.i_b_out    (fn_out[gi]),
				.i_b_oe     (fn_oe[gi]),
				.i_pin_sync (sync2[gi]),
				.o_pin_out  (o_pin_out[gi]),
				.o_pin_oe   (o_pin_oe[gi]),
				.o_a_in     (),
				.o_b_in     (fn_in[gi])
			);
		end
	endgenerate

	assign o_uart2_ring_indicator = fn_in[UPPER_UART_LSB + 3];
	assign o_uart2_carrier_detect = fn_in[UPPER_UART_LSB + 2];
	assign o_uart2_set_ready      = fn_in[UPPER_UART_LSB + 1];
	assign o_uart2_clear_to_send  = fn_in[UPPER_UART_LSB];
	assign o_gp_mem_16bit_ack     = fn_in[UPPER_MEM16_BIT];
	assign o_gp_io_16bit_ack      = fn_in[UPPER_IO16_BIT];

	generate
		for (gi = 0; gi < 8; gi++) begin : g_irq
			assign o_gp_irq_input_n[gi] = fn_in[UPPER_IRQ_MSB - gi];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Chip select shared pins
	// ---------------------------------------------------------------
	logic [7:1] pri_out;
	logic [7:1] pri_oe;
	logic [7:1] pri_in;

	always_comb begin
		pri_out = 7'h7f;
		pri_oe  = 7'h00;
		pri_out[CS_TIMER0_OUTPUT_BIT] = i_timer0_output;
		pri_oe[CS_TIMER0_OUTPUT_BIT]  = 1'b1;
		pri_out[CS_TIMER1_OUTPUT_BIT] = i_timer1_output;
		pri_oe[CS_TIMER1_OUTPUT_BIT]  = 1'b1;
		pri_out[CS_ROM2_BIT]    = i_boot_rom_select_2;
		pri_oe[CS_ROM2_BIT]     = 1'b1;
		pri_out[CS_ROM1_BIT]    = i_boot_rom_select_1;
		pri_oe[CS_ROM1_BIT]     = 1'b1;
	end

	generate
		for (gi = 1; gi < 8; gi++) begin : g_cs
			pfsm_pin_cell #(
				.IDLE_A (1'b0),
				.IDLE_B (1'b1)
			) u_cell (
				.i_sel      (cs_fnc[gi]),
				.i_a_out    (pri_out[gi]),
				.i_a_oe     (pri_oe[gi]),
				.i_b_out    (i_gp_chip_select_n[gi]),
				.i_b_oe     (1'b1),
				.i_pin_sync (sync2[15 + gi]),
				.o_pin_out  (o_cs_pin_out[gi]),
				.o_pin_oe   (o_cs_pin_oe[gi]),
				.o_a_in     (pri_in[gi]),
				.o_b_in     ()
			);
		end
	endgenerate

	assign o_timer0_input         = pri_in[CS_TIMER0_INPUT_BIT];
	assign o_timer1_input         = pri_in[CS_TIMER1_INPUT_BIT];
	assign o_interval_timer2_gate = pri_in[CS_GATE2_BIT];

endmodule // pfsm_pin_function_select_mux

// file: pfsm_pkg.sv
// Operation
// - A 32-bit access at C20h runs as lower half, then upper half, never together.
// - Upper select bit n gives pin n+16: 0 programmable I/O, 1 interface function.
// - Upper bits 15..12 give ring indicator, carrier detect, set ready, clear to send.
// - Upper bits 11..8 give chip select zero, memory ack, I/O ack, buffer enable.
// - Upper bits 7..0 give interrupt inputs 0..7 in reverse order.
// - All upper select bits reset to 0, making every pin programmable I/O driven by i_pio_out and i_pio_oe.
// - Chip select bits 7 and 6 choose timer outputs or chip selects seven, six.
// - Chip select bits 5 and 4 choose timer inputs or chip selects five, four.
// - Chip select bit 3 chooses interval timer gate or chip select three.
// - Chip select bits 2 and 1 choose boot ROM selects or chip selects two, one.
// - All chip select bits reset to 0, showing the primary functions.
// - Chip select zero has no chip select bit; only upper bit 11 picks it.
// - With select 1, direction, data, set and clear writes for the pin have no effect.
// - Each pin's data bit always reads the current pin level.
package pfsm_pkg;

	localparam int unsigned   ADDR_W          = 12;
	localparam logic [11:0]   OFS_LOWER_FNC   = 12'h0c20;
	localparam logic [11:0]   OFS_UPPER_FNC   = 12'h0c22;
	localparam logic [11:0]   OFS_CS_FNC      = 12'h0c24;
	localparam logic [15:0]   UPPER_FNC_RESET = 16'h0000;
	localparam logic [7:0]    CS_FNC_RESET    = 8'h00;
	localparam logic [7:0]    CS_FNC_WRITABLE = 8'hfe;
	localparam int unsigned   UPPER_UART_LSB  = 12;
	localparam int unsigned   UPPER_CS0_BIT   = 11;
	localparam int unsigned   UPPER_MEM16_BIT = 10;
	localparam int unsigned   UPPER_IO16_BIT  = 9;
	localparam int unsigned   UPPER_DBUF_BIT  = 8;
	localparam int unsigned   UPPER_IRQ_MSB   = 7;
	localparam int unsigned   CS_TIMER0_OUTPUT_BIT  = 7;
	localparam int unsigned   CS_TIMER1_OUTPUT_BIT  = 6;
	localparam int unsigned   CS_TIMER0_INPUT_BIT   = 5;
	localparam int unsigned   CS_TIMER1_INPUT_BIT   = 4;
	localparam int unsigned   CS_GATE2_BIT    = 3;
	localparam int unsigned   CS_ROM2_BIT     = 2;
	localparam int unsigned   CS_ROM1_BIT     = 1;

	typedef enum logic [1:0] {
		SIZE_BYTE  = 2'h0,
		SIZE_WORD  = 2'h1,
		SIZE_DWORD = 2'h2
	} pfsm_size_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_LOWER = 3'h2,
		ST_UPPER = 3'h4
	} pfsm_state_t;

endpackage

// file: pfsm_pin_cell.sv
`timescale 1ns/100ps

// ---------------------------------------------------------------
// Two-way pin shared by a primary source (a) and an alternate (b)
// ---------------------------------------------------------------
module pfsm_pin_cell #(
	parameter logic IDLE_A = 1'b0,
	parameter logic IDLE_B = 1'b1
) (
	input  wire logic i_sel,
	input  wire logic i_a_out,
	input  wire logic i_a_oe,
	input  wire logic i_b_out,
	input  wire logic i_b_oe,
	input  wire logic i_pin_sync,
	output logic      o_pin_out,
	output logic      o_pin_oe,
	output logic      o_a_in,
	output logic      o_b_in
);
	// The function that does not own the pin sees its idle level, so
	// a deselected input never picks up traffic meant for the other.
	always_comb begin
		o_pin_out = i_sel ? i_b_out : i_a_out;
		o_pin_oe  = i_sel ? i_b_oe : i_a_oe;
		o_a_in    = i_sel ? IDLE_A : i_pin_sync;
		o_b_in    = i_sel ? i_pin_sync : IDLE_B;
	end
endmodule // pfsm_pin_cell

// file: pfsm_assertions.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Port checker for the function-select block
// ------------------------------------------------------------
module pfsm_checker
	import pfsm_pkg::*;
(
	input wire logic                 i_mclk,
	input wire logic                 i_rst,
	input wire logic                 i_req,
	input wire logic                 i_we,
	input wire pfsm_pkg::pfsm_size_t i_size,
	input wire logic [11:0]          i_addr,
	input wire logic [31:0]          i_wdata,
	input wire logic                 o_ready,
	input wire logic                 o_ack,
	input wire logic                 o_lower_req,
	input wire logic                 o_lower_we,
	input wire logic [15:0]          o_lower_wdata,
	input wire logic [15:0]          o_upper_fnc,
	input wire logic [7:0]           o_cs_fnc,
	input wire logic [15:0]          i_pio_out,
	input wire logic [15:0]          i_pio_oe,
	input wire logic [15:0]          o_pin_out,
	input wire logic [15:0]          o_pin_oe,
	input wire logic [7:0]           i_gp_chip_select_n,
	input wire logic                 i_gp_data_buffer_oe,
	input wire logic                 i_timer0_output,
	input wire logic                 o_timer0_input,
	input wire logic [7:1]           o_cs_pin_out,
	input wire logic [7:1]           o_cs_pin_oe
);
	logic        take;
	logic [15:0] wd_hi;
	logic [15:0] wd_lo;

	assign take = i_req & o_ready;
	assign wd_hi = i_wdata[31:16];
	assign wd_lo = i_wdata[15:0];

	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	sequence dw;
		take && i_we && i_size == SIZE_DWORD && i_addr == OFS_LOWER_FNC;
	endsequence

	upper_reset_a: assert property ($fell(i_rst) |-> !o_upper_fnc)
		else $error("upper select not clear after reset");
	cs_reset_a: assert property ($fell(i_rst) |-> !o_cs_fnc)
		else $error("chip select register not clear after reset");
	cs_rsv_zero_a: assert property (!o_cs_fnc[0])
		else $error("reserved chip select bit set");
	// The upper half must not move while the lower half is being written.
	dword_split_a: assert property (dw |=>
		o_lower_req && o_lower_we && o_lower_wdata == $past(wd_lo)
		&& $stable(o_upper_fnc) ##1 !o_lower_req && !o_ack
		##1 o_ack && o_upper_fnc == $past(wd_hi, 3))
		else $error("dword write not split lower then upper");
	upper_word_a: assert property (take && i_we && i_size == SIZE_WORD
		&& i_addr == OFS_UPPER_FNC |-> ##2 o_ack && o_upper_fnc == $past(wd_hi, 2))
		else $error("upper select word write wrong");
	pio_pass_a: assert property ((((o_pin_out ^ i_pio_out)
		| (o_pin_oe ^ i_pio_oe)) & ~o_upper_fnc) == 16'h0000)
		else $error("pin not passing programmable io drive");
	alt_drive_a: assert property (o_upper_fnc[11] |-> o_pin_oe[11]
		&& o_pin_out[11] == i_gp_chip_select_n[0] && (!o_upper_fnc[8]
		|| o_pin_oe[8] && o_pin_out[8] == i_gp_data_buffer_oe))
		else $error("alternate output pin drive wrong");
	alt_input_a: assert property ((o_pin_oe & o_upper_fnc & 16'hf6ff) == 0)
		else $error("alternate input pin is driven");
	cs_drive_a: assert property (o_cs_pin_oe[7] && o_cs_pin_out[7] ==
		(o_cs_fnc[7] ? i_gp_chip_select_n[7] : i_timer0_output))
		else $error("timer or chip select pin drive wrong");
	timer_in_a: assert property (o_cs_fnc[5] && $past(o_cs_fnc[5], 3)
		|-> !o_timer0_input)
		else $error("timer input seen while chip select chosen");

	cover property (dw);
	cover property (o_upper_fnc[11]);
	cover property (o_cs_fnc[7]);
endmodule // pfsm_checker

bind pfsm_pin_function_select_mux pfsm_checker i_pfsm_checker (.*);

// file: pfsm_pin_function_select_mux_tb.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Bench with a stand-in lower register
// ------------------------------------------------------------
module pfsm_pin_function_select_mux_tb;
	import pfsm_pkg::*;
	logic        i_mclk, i_rst, i_req, i_we, o_ready, o_ack;
	logic        o_lower_req, o_lower_we, i_gp_data_buffer_oe;
	logic        o_uart2_ring_indicator, o_uart2_carrier_detect;
	logic        o_uart2_set_ready, o_uart2_clear_to_send;
	logic        o_gp_mem_16bit_ack, o_gp_io_16bit_ack, i_timer0_output;
	logic        i_timer1_output, o_timer0_input, o_timer1_input;
	logic        o_interval_timer2_gate, i_boot_rom_select_1;
	logic        i_boot_rom_select_2;
	pfsm_size_t  i_size;
	logic [1:0]  o_lower_be;
	logic [7:0]  o_cs_fnc, i_gp_chip_select_n, o_gp_irq_input_n;
	logic [7:1]  i_cs_pin_in, o_cs_pin_out, o_cs_pin_oe;
	logic [11:0] i_addr;
	logic [15:0] o_lower_wdata, i_lower_rdata, o_upper_fnc, o_pin_level;
	logic [15:0] o_pio_write_allow, i_pio_out, i_pio_oe, i_pin_in;
	logic [15:0] o_pin_out, o_pin_oe;
	logic [31:0] i_wdata, o_rdata, rd;
	logic [3:0]  uart;
	int          n_errors, n_checks;

	pfsm_pin_function_select_mux i_pfsm_pin_function_select_mux (.*);

	assign uart = {o_uart2_ring_indicator, o_uart2_carrier_detect,
		o_uart2_set_ready, o_uart2_clear_to_send};

	// The lower register lives outside the block, so the bench keeps it.
	always @(posedge i_mclk) begin
		if (i_rst) begin
			i_lower_rdata <= 16'h0000;
		end else if (o_lower_req && o_lower_we) begin
			if (o_lower_be[0]) begin
				i_lower_rdata[7:0] <= o_lower_wdata[7:0];
			end
			if (o_lower_be[1]) begin
				i_lower_rdata[15:8] <= o_lower_wdata[15:8];
			end
		end
	end

	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request is held until the edge that takes it; answer read at ack.
	task automatic acc(input logic w, pfsm_size_t s, logic [11:0] a,
		logic [31:0] d);
		i_req <= 1'b1;
		i_we <= w;
		i_size <= s;
		i_addr <= a;
		i_wdata <= d;
		do begin
			@(posedge i_mclk);
		end while (o_ready !== 1'b1);
		i_req <= 1'b0;
		repeat (8) begin
			@(posedge i_mclk);
			if (o_ack === 1'b1) break;
		end
		chk("ack", 1'b1, o_ack);
		rd = o_rdata;
	endtask

	// Pin inputs pass two sync flops, so allow them to settle.
	task automatic settle;
		repeat (4) @(posedge i_mclk);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (1000) @(posedge i_mclk);
		n_errors++;
		end_of_test;
	end

	initial begin
		i_rst = 1'b1;
		i_req = 1'b0;
		i_we = 1'b0;
		i_size = SIZE_WORD;
		i_addr = 12'h0000;
		i_wdata = 32'h0000_0000;
		i_pio_out = 16'h1234;
		i_pio_oe = 16'h00ff;
		i_pin_in = 16'ha503;
		i_gp_chip_select_n = 8'h5a;
		i_gp_data_buffer_oe = 1'b1;
		i_timer0_output = 1'b1;
		i_timer1_output = 1'b0;
		i_boot_rom_select_1 = 1'b1;
		i_boot_rom_select_2 = 1'b0;
		i_cs_pin_in = 7'h55;
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		acc(0, SIZE_WORD, OFS_UPPER_FNC, 0);
		chk("upper", 16'h0000, rd[31:16]);
		acc(0, SIZE_BYTE, OFS_CS_FNC, 0);
		chk("cs", 8'h00, rd[7:0]);
		chk("pin_out", 16'h1234, o_pin_out);
		chk("pin_oe", 16'h00ff, o_pin_oe);
		$display("reset test done");
		acc(1, SIZE_BYTE, OFS_CS_FNC, 32'h0000_0000);
		acc(1, SIZE_DWORD, OFS_LOWER_FNC, 32'h5a5a_a5a5);
		chk("lower", 16'ha5a5, i_lower_rdata);
		chk("upper", 16'h5a5a, o_upper_fnc);
		acc(0, SIZE_DWORD, OFS_LOWER_FNC, 0);
		chk("dword", 32'h5a5a_a5a5, rd);
		acc(1, SIZE_BYTE, 12'h0c21, 32'h0000_3c00);
		chk("lower_byte", 16'h3ca5, i_lower_rdata);
		acc(0, SIZE_WORD, OFS_LOWER_FNC, 32'h0000_0000);
		chk("lower_rd", 32'h0000_3ca5, rd);
		$display("dword test done");
		acc(1, SIZE_WORD, OFS_UPPER_FNC, 32'hffff_0000);
		settle;
		chk("allow", 16'h0000, o_pio_write_allow);
		chk("level", 16'ha503, o_pin_level);
		chk("uart", 4'ha, uart);
		chk("ack16", 2'b10, {o_gp_mem_16bit_ack, o_gp_io_16bit_ack});
		chk("irq", 8'hc0, o_gp_irq_input_n);
		chk("alt_oe", 16'h0900, o_pin_oe);
		chk("alt_out", 16'h0100, o_pin_out & 16'h0900);
		acc(1, SIZE_WORD, OFS_UPPER_FNC, 32'h0004_0000);
		settle;
		chk("irq5", 8'hdf, o_gp_irq_input_n);
		chk("uart_idle", 4'hf, uart);
		chk("allow", 16'hfffb, o_pio_write_allow);
		$display("upper select test done");
		acc(1, SIZE_BYTE, OFS_CS_FNC, 32'h0000_00fe);
		acc(0, SIZE_BYTE, OFS_CS_FNC, 0);
		chk("cs_rd", 8'hfe, rd[7:0]);
		settle;
		chk("cs_out", 7'h2d, o_cs_pin_out);
		chk("cs_oe", 7'h7f, o_cs_pin_oe);
		chk("tin", 3'b000, {o_timer0_input, o_timer1_input,
			o_interval_timer2_gate});
		acc(1, SIZE_BYTE, OFS_CS_FNC, 0);
		settle;
		chk("cs_oe", 7'h63, o_cs_pin_oe);
		chk("cs_out", 7'h41, o_cs_pin_out & 7'h63);
		chk("tin", 3'b101, {o_timer0_input, o_timer1_input,
			o_interval_timer2_gate});
		$display("chip select test done");
		acc(0, SIZE_BYTE, 12'h0c26, 0);
		chk("unmapped", 32'h0000_0000, rd);
		acc(1, SIZE_WORD, 12'h0c23, 32'hffff_ffff);
		chk("misaligned", 16'h0004, o_upper_fnc);
		acc(1, SIZE_BYTE, 12'h0c23, 32'h8100_0000);
		chk("upper_byte", 16'h8104, o_upper_fnc);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		chk("upper_rst", 16'h0000, o_upper_fnc);
		chk("cs_rst", 8'h00, o_cs_fnc);
		$display("refusal and reset test done");
		end_of_test;
	end
endmodule // pfsm_pin_function_select_mux_tb
